/* File: shared/pga_link_if.sv */
/*
 serial link between host master and one amplifier: clock, select,
 data to device, data from device.
 assumes: host drives sck, cs_n and si; device drives so.
*/
`timescale 1ns/1ns
interface pga_link_if;
    logic sck;   // serial clock from host
    logic cs_n;  // chip select, active low
    logic si;    // data into device
    logic so;    // data out of device
    modport host (output sck, output cs_n, output si, input so);
    modport dev  (input sck, input cs_n, input si, output so);
endinterface

/* File: shared/pga_map.svh */
/*
 holds the timing counts, word sizes and command field layout for the
 serial gain amplifier link, as macros.
 assumes: included by the package and by both ends; no other definitions.
*/
// Function
// - host chains data out to data in, shares clock
// - data moves in sixteen bit words of two bytes
// - bit count not multiple of sixteen discards transfer
// - select rising executes word then clears shift register
// - first sixteen bits out after select falls are zero
// - zero word gives next device a no-operation command
// - host may omit words for farthest devices
// - host keeps serial clock at most about 5.8 MHz
// - outputless variants sit only at chain end
// - reset returns all registers to defaults
// - reset forces shutdown over software state
// - reset release frees forced shutdown
// - shutdown holds until valid non-shutdown non-noop command
// - registers kept unchanged during shutdown
`ifndef PGA_MAP_SVH
`define PGA_MAP_SVH
`define WORD_BITS          16
`define CLOCK_MHZ_X10      100
`define LINK_MAX_MHZ_X10   58
// half period of link clock in block cycles; far below the rate limit
// because every hop costs two sync stages plus one cycle to react, and
// the return data must settle in the host before it is sampled
`define LINK_HALF_CYCLES   4
`define CMD_OP_HI          15
`define CMD_OP_LO          13
`define OP_NOOP            3'h0
`define OP_SHUTDOWN        3'h1
`define OP_WRITE           3'h2
`define CMD_ADDR_BIT       8
`define GAIN_DEFAULT       3'h0
`define CHAN_DEFAULT       3'h0
`endif

/* File: shared/pga_pkg.sv */
/*
 types shared by both link ends.
 assumes: pga_map.svh on the include path.
*/
`include "pga_map.svh"
package pga_pkg;
    typedef logic [`WORD_BITS-1:0] word_t;  // one link word
    typedef enum logic [2:0] {
        host_idle  = 3'b001,
        host_shift = 3'b010,
        host_done  = 3'b100
    } host_state_e;
endpackage

/* File: src/pga_dev.sv */
/*
 amplifier serial front end: shifts words while selected, runs the
 command on select rise, tracks shutdown and gain/channel state.
 assumes: link pins arrive asynchronously; reset stands for power-on.
*/
`timescale 1ns/1ns
`include "pga_map.svh"
module pga_dev
    import pga_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic clk_en,
    pga_link_if.dev   link,
    output logic [2:0] gain_r,
    output logic [2:0] chan_r,
    output logic      shutdown,
    output logic      cmd_pulse
);
    logic [2:0] sck_s_r, cs_s_r;   // two syncs plus history
    logic [1:0] si_s_r;            // data sync
    word_t      shift_r;           // internal shift register
    logic [3:0] cnt_r;             // bits mod sixteen
    logic       sd_r;              // software shutdown
    logic       so_r;              // registered data out
    logic       cmd_r;

    // edges seen only on second stage and its history
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire cs_low   = ~cs_s_r[1];
    wire cs_rise  = cs_s_r[1] & ~cs_s_r[2];
    wire whole    = (cnt_r == 4'h0);
    wire [2:0] op = shift_r[`CMD_OP_HI:`CMD_OP_LO];
    wire do_exec  = cs_rise & whole;
    wire is_write = do_exec & (op == `OP_WRITE);
    wire is_sd    = do_exec & (op == `OP_SHUTDOWN);

    // synchronisers
    always_ff @(posedge clock) begin
        if (reset) begin
            sck_s_r <= 3'h0;
            cs_s_r  <= 3'h7;
            si_s_r  <= 2'h0;
        end else if (clk_en) begin
            sck_s_r <= {sck_s_r[1:0], link.sck};
            cs_s_r  <= {cs_s_r[1:0], link.cs_n};
            si_s_r  <= {si_s_r[0], link.si};
        end
    end

    // shifting; clear on select rise gives zero first word out
    always_ff @(posedge clock) begin
        if (reset) begin
            shift_r <= '0;
            cnt_r   <= 4'h0;
            so_r    <= 1'b0;
        end else if (clk_en) begin
            if (cs_rise) begin
                shift_r <= '0;
                cnt_r   <= 4'h0;
            end else if (cs_low && sck_rise) begin
                shift_r <= {shift_r[`WORD_BITS-2:0], si_s_r[1]};
                cnt_r   <= cnt_r + 4'h1;
            end
            // far bit shows after falling edge, stable for next rise
            if (cs_low && sck_fall)
                so_r <= shift_r[`WORD_BITS-1];
            else if (!cs_low)
                so_r <= 1'b0;
        end
    end

    // command execution; noop touches only the command pulse
    always_ff @(posedge clock) begin
        if (reset) begin
            gain_r <= `GAIN_DEFAULT;
            chan_r <= `CHAN_DEFAULT;
            sd_r   <= 1'b0;
            cmd_r  <= 1'b0;
        end else if (clk_en) begin
            cmd_r <= do_exec;
            if (is_write) begin
                // write leaves shutdown, old settings still held
                if (shift_r[`CMD_ADDR_BIT])
                    chan_r <= shift_r[2:0];
                else
                    gain_r <= shift_r[2:0];
                sd_r <= 1'b0;
            end else if (is_sd) begin
                sd_r <= 1'b1;
            end
        end
    end

    // reset overrides software state, released with it
    assign shutdown  = reset | sd_r;
    assign cmd_pulse = cmd_r;
    assign link.so   = so_r;
endmodule

/* File: src/pga_host.sv */
/*
 host master: sends a number of words on the chain, makes the serial
 clock by dividing its own clock, raises select to execute.
 assumes: words are presented one at a time on wdata; only the first is taken with start/wready, later ones without handshake.
*/
`timescale 1ns/1ns
`include "pga_map.svh"
module pga_host
    import pga_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  reset,
    input  wire logic  clk_en,
    input  wire logic  start,
    input  wire logic [3:0] words,
    input  wire word_t wdata,
    output logic       wready,
    output word_t      rdata,
    output logic       rvalid,
    output logic       busy,
    pga_link_if.host   link
);
    host_state_e state_r;
    logic [3:0] div_r;       // half period count
    logic       sck_r;
    logic [3:0] bit_r;
    logic [3:0] left_r;      // words still to send
    word_t      tx_r, rx_r, rdata_r;
    logic [1:0] so_s_r;
    logic       rv_r;

    wire half   = (div_r == 4'(`LINK_HALF_CYCLES - 1));
    wire last_b = (bit_r == 4'hf);
    wire rise   = half & ~sck_r;
    wire fall   = half & sck_r;

    assign wready = (state_r == host_idle) & start & (words != 4'h0);

    // state and clock divider
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= host_idle;
            div_r <= 4'h0;
            sck_r <= 1'b0;
            bit_r <= 4'h0;
            left_r <= 4'h0;
            tx_r <= '0;
            rx_r <= '0;
            rdata_r <= '0;
            rv_r <= 1'b0;
            so_s_r <= 2'h0;
        end else if (clk_en) begin
            so_s_r <= {so_s_r[0], link.so};
            rv_r <= 1'b0;
            unique case (state_r)
            host_idle: begin
                div_r <= 4'h0;
                if (wready) begin
                    tx_r <= wdata;
                    left_r <= words;
                    bit_r <= 4'h0;
                    state_r <= host_shift;
                end
            end
            host_shift: begin
                div_r <= half ? 4'h0 : div_r + 4'h1;
                if (rise) begin
                    sck_r <= 1'b1;
                end else if (fall) begin
                    sck_r <= 1'b0;
                    // return data lags by the chain's syncs; take the bit
                    // of this period at its falling edge, not the rise
                    rx_r <= {rx_r[`WORD_BITS-2:0], so_s_r[1]};
                    bit_r <= bit_r + 4'h1;
                    tx_r <= {tx_r[`WORD_BITS-2:0], 1'b0};
                    if (last_b) begin
                        rdata_r <= {rx_r[`WORD_BITS-2:0], so_s_r[1]};
                        rv_r <= 1'b1;
                        left_r <= left_r - 4'h1;
                        tx_r <= wdata;
                        if (left_r == 4'h1)
                            state_r <= host_done;
                    end
                end
            end
            host_done: begin
                state_r <= host_idle;
            end
            default: state_r <= host_idle;
            endcase
        end
    end

    assign link.sck  = sck_r;
    assign link.cs_n = (state_r != host_shift);
    assign link.si   = tx_r[`WORD_BITS-1];
    assign rdata     = rdata_r;
    assign rvalid    = rv_r;
    assign busy      = (state_r != host_idle);
endmodule

/* File: verif/pga_link_monitor.sv */
/*
 concurrent checks on one serial link between host and first amplifier.
 assumes: plain link signals sampled on the block clock, reset high.
*/
`timescale 1ns/1ns
module pga_link_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so
);
    logic       sck_q_r;  // link clock one cycle back
    logic [4:0] bits_r;   // rises while selected, wraps into 16..31
    wire        rise = sck & ~sck_q_r;
    // count rises; wrap keeps low bits exact past one word
    always_ff @(posedge clock) begin
        sck_q_r <= sck;
        if (reset || cs_n)
            bits_r <= 5'h00;
        else if (rise)
            bits_r <= (bits_r == 5'h1f) ? 5'h10 : bits_r + 5'h01;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_first_rise;
        ##[1:40] $rose(sck);
    endsequence
    chk_sck_rate: assert property ($rose(sck) |-> ##4 $fell(sck))
        else $error("link clock high time wrong");
    chk_sck_parked: assert property (cs_n |-> !sck)
        else $error("link clock runs while deselected");
    chk_whole_words: assert property
        ($rose(cs_n) |-> bits_r[3:0] == 4'h0 && bits_r != 5'h00)
        else $error("select rose mid word");
    // skip the first bits: output lags a falling edge by up to 3 cycles
    chk_lead_zero: assert property
        (!cs_n && bits_r >= 5'h03 && bits_r < 5'h10 |-> !so)
        else $error("leading word not zero");
    chk_si_on_low: assert property ($changed(si) |-> !sck)
        else $error("data moved while clock high");
    chk_first_rise: assert property ($fell(cs_n) |-> s_first_rise)
        else $error("no clock after select");
    chk_select_held: assert property ($fell(cs_n) |=> !cs_n[*8])
        else $error("select bounced");
    chk_reset_idle: assert property
        ($fell(reset) |-> cs_n && !sck && !so)
        else $error("link not idle after reset");
endmodule

/* File: verif/test_pga_spi_daisy_chain_por.sv */
/*
 bench: host drives a two-amplifier chain; a third amplifier is driven
 bit by bit to send whole and broken transfers.
 assumes: pga_map.svh on the include path, 10 MHz clock.
*/
`timescale 1ns/1ns
`include "pga_map.svh"
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_pga_spi_daisy_chain_por
    import pga_pkg::*;
;
    logic       clock = 0, reset = 1, start = 0, wready, rvalid, busy;
    logic [3:0] words = 0;              // word count for the host
    word_t      wdata = 0, rdata, last_rd = 0;
    logic [2:0] gain [3], chan [3];     // per amplifier state
    logic       sd [3], pulse [3];
    int         failures = 0, n_tests = 0;
    pga_link_if lh(), l0(), l1(), lt();
    // chain: host data into first, first out into second, last back
    // shared clock and select on both chained devices
    assign l0.sck = lh.sck;
    assign l0.cs_n = lh.cs_n;
    assign l0.si = lh.si;
    assign l1.sck = lh.sck;
    assign l1.cs_n = lh.cs_n;
    assign l1.si = l0.so;
    assign lh.so = l1.so;
    always #50 clock = ~clock;
    always @(posedge clock) if (rvalid === 1'b1) last_rd <= rdata;
    int         n_exec0 = 0, n_exec2 = 0;  // executed transfers seen
    // count command pulses of the first and the standalone amplifier
    always @(posedge clock) begin
        if (pulse[0] === 1'b1)
            n_exec0 <= n_exec0 + 1;
        if (pulse[2] === 1'b1)
            n_exec2 <= n_exec2 + 1;
    end
    pga_host i_pga_host (.clock(clock), .reset(reset), .clk_en(1'b1),
        .start(start), .words(words), .wdata(wdata), .wready(wready),
        .rdata(rdata), .rvalid(rvalid), .busy(busy), .link(lh));
    pga_dev i_pga_dev0 (.clock(clock), .reset(reset), .clk_en(1'b1),
        .link(l0), .gain_r(gain[0]), .chan_r(chan[0]),
        .shutdown(sd[0]), .cmd_pulse(pulse[0]));
    pga_dev i_pga_dev1 (.clock(clock), .reset(reset), .clk_en(1'b1),
        .link(l1), .gain_r(gain[1]), .chan_r(chan[1]),
        .shutdown(sd[1]), .cmd_pulse(pulse[1]));
    // standalone amplifier sits at a chain end; data out unread
    pga_dev i_pga_dev2 (.clock(clock), .reset(reset), .clk_en(1'b1),
        .link(lt), .gain_r(gain[2]), .chan_r(chan[2]),
        .shutdown(sd[2]), .cmd_pulse(pulse[2]));
    pga_link_monitor i_mon (.clock(clock), .reset(reset), .sck(l0.sck),
        .cs_n(l0.cs_n), .si(l0.si), .so(l0.so));
    function automatic word_t cmd(logic [2:0] op, logic ch, logic [2:0] v);
        return {op, 4'h0, ch, 5'h00, v};
    endfunction
    // host transfer; b also serves every word after the first
    task automatic send(input logic [3:0] n, input word_t a, b);
        int t;
        t = 0;
        @(posedge clock);
        words <= n;
        wdata <= a;
        start <= 1'b1;
        @(negedge clock);
        while (wready !== 1'b1) @(negedge clock);
        @(posedge clock);
        wdata <= b;
        start <= 1'b0;
        @(negedge clock);
        while (busy !== 1'b0 && t < 1000) begin
            @(negedge clock);
            t++;
        end
        if (t >= 1000)
            failures++;
        repeat (8) @(negedge clock);
        $display("done: host transfer of %0d words", n);
    endtask
    // bench link clock at 800 ns, still between frames
    task automatic bang(input logic [31:0] v, input int n);
        lt.cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            lt.si <= v[31-i];
            repeat (4) @(posedge clock);
            lt.sck <= 1'b1;
            repeat (4) @(posedge clock);
            lt.sck <= 1'b0;
        end
        repeat (4) @(posedge clock);
        lt.cs_n <= 1'b1;
        lt.si <= ~lt.si;  // released line must not hold its last bit
        repeat (12) @(negedge clock);
        $display("done: bench frame of %0d bits", n);
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2_000_000;
        failures++;
        report_and_stop();
    end
    initial begin
        lt.sck <= 1'b0;
        lt.cs_n <= 1'b1;
        lt.si <= 1'b0;
        repeat (11) @(posedge clock);
        @(negedge clock);
        `CHECK("sd0", 1'b1, sd[0])
        `CHECK("gain0", 3'h0, gain[0])
        @(posedge clock) reset <= 1'b0;
        @(negedge clock);
        `CHECK("sd0", 1'b0, sd[0])
        send(4'h1, cmd(`OP_WRITE, 1'b0, 3'h5), 16'h0000);
        `CHECK("gain0", 3'h5, gain[0])
        `CHECK("sd1", 1'b0, sd[1])
        `CHECK("gain1", 3'h0, gain[1])
        `CHECK("exec0", 1, n_exec0)
        send(4'h2, cmd(`OP_WRITE, 1'b1, 3'h3), cmd(`OP_SHUTDOWN, 1'b0, 3'h0));
        `CHECK("chan1", 3'h3, chan[1])
        `CHECK("sd0", 1'b1, sd[0])
        `CHECK("rx", 16'h0000, last_rd)
        send(4'h2, 16'h0000, 16'h0000);
        `CHECK("sd0", 1'b1, sd[0])
        `CHECK("gain0", 3'h5, gain[0])
        send(4'h3, cmd(`OP_WRITE, 1'b0, 3'h7), cmd(`OP_WRITE, 1'b1, 3'h6));
        `CHECK("sd0", 1'b0, sd[0])
        `CHECK("chan0", 3'h6, chan[0])
        `CHECK("exec0", 4, n_exec0)
        `CHECK("rx", cmd(`OP_WRITE, 1'b0, 3'h7), last_rd)
        bang({cmd(`OP_WRITE, 1'b0, 3'h3), 16'h0000}, 16);
        `CHECK("gain2", 3'h3, gain[2])
        bang({1'b0, cmd(`OP_WRITE, 1'b0, 3'h6), 15'h0000}, 17);
        `CHECK("gain2", 3'h3, gain[2])
        `CHECK("exec2", 1, n_exec2)
        bang({cmd(`OP_WRITE, 1'b0, 3'h2), cmd(`OP_WRITE, 1'b0, 3'h4)}, 32);
        `CHECK("gain2", 3'h4, gain[2])
        `CHECK("exec2", 2, n_exec2)
        @(posedge clock) reset <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        `CHECK("sd0", 1'b1, sd[0])
        `CHECK("chan0", 3'h0, chan[0])
        @(posedge clock) reset <= 1'b0;
        @(negedge clock);
        `CHECK("sd0", 1'b0, sd[0])
        `CHECK("gain2", 3'h0, gain[2])
        $display("done: reset in mid run");
        report_and_stop();
    end
endmodule
